// ===== inc/mds_pkg.sv
// Constants for the motor driver status register bank.
// Assumes a 16-bit register port with 8-bit word addresses.
package mds_pkg;
  localparam int          MDS_DATA_W        = 16;
  localparam int          MDS_ADDR_W        = 8;
  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [7:0]  MDS_OFS_DEV_STS   = 8'h00;
  localparam logic [7:0]  MDS_OFS_OVERTEMP_STATUS    = 8'h04;
  localparam logic [7:0]  MDS_OFS_SUPPLY_STATUS   = 8'h05;
  localparam logic [7:0]  MDS_OFS_DRIVER_STATUS   = 8'h06;
  localparam logic [7:0]  MDS_OFS_SYSTEM_STATUS   = 8'h07;
  localparam logic [7:0]  MDS_OFS_SYNC_PRD  = 8'h0c;
  localparam logic [7:0]  MDS_OFS_FAULT_MODE  = 8'h10;
  localparam logic [7:0]  MDS_OFS_SYSF_CTL  = 8'h12;
  localparam logic [7:0]  MDS_OFS_DRVF_CTL  = 8'h13;
  localparam logic [7:0]  MDS_OFS_FLT_TIME  = 8'h16;
  localparam logic [7:0]  MDS_OFS_FAULT_CLEAR   = 8'h17;
  localparam logic [7:0]  MDS_OFS_PG_PERIOD = 8'h18;
  localparam logic [7:0]  MDS_OFS_PG_DUTY_A = 8'h19;
  localparam logic [7:0]  MDS_OFS_PG_DUTY_B = 8'h1a;
  localparam logic [7:0]  MDS_OFS_PG_DUTY_C = 8'h1b;
  localparam logic [7:0]  MDS_OFS_PWM_STATE = 8'h1c;
  localparam logic [7:0]  MDS_OFS_PG_CTRL   = 8'h1d;
  localparam logic [7:0]  MDS_OFS_PWM_CTL1  = 8'h20;
  localparam logic [7:0]  MDS_OFS_PREDRV    = 8'h22;
  localparam logic [7:0]  MDS_OFS_SENSE     = 8'h23;
  localparam logic [7:0]  MDS_OFS_SYSTEM_CONTROL  = 8'h3f;
  localparam int          MDS_NUM_RW        = 16;
  // --------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------
  localparam int          MDS_BIT_PARITY    = 15;
  localparam int          MDS_BIT_OTP       = 8;
  localparam int          MDS_BIT_POR       = 7;
  localparam int          MDS_BIT_SERIAL    = 6;
  localparam int          MDS_BIT_OCP       = 5;
  localparam int          MDS_BIT_UV        = 2;
  localparam int          MDS_BIT_OT        = 1;
  localparam int          MDS_BIT_FAULT     = 0;
  localparam int          MDS_BIT_REG_OTS   = 2;
  localparam int          MDS_BIT_OTW       = 1;
  localparam int          MDS_BIT_OVERTEMP_SHUTDOWN      = 0;
  localparam logic [15:0] MDS_RST_DEV_STS   = 16'h0080;
  localparam logic [15:0] MDS_RST_OVERTEMP_STATUS    = 16'h0000;
  localparam logic [15:0] MDS_RST_RW        = 16'h0000;
  localparam logic [15:0] MDS_RST_ZERO      = 16'h0000;
  // Access state of the register port
  typedef enum logic [1:0] {
    MDS_ST_IDLE = 2'b00,
    MDS_ST_READ = 2'b01,
    MDS_ST_DONE = 2'b11
  } mds_state_t;
endpackage

// ===== rtl/mds_parity.sv
// Parity generator for a 15-bit read payload.
// Assumes nothing of its surroundings; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module mds_parity
  import mds_pkg::*;
#(
  parameter int WIDTH = 15
)
(
  input  wire logic [WIDTH-1:0] data_i,
  output logic                  parity_o
);
  // --------------------------------------------------------------
  // Even parity over the payload
  // --------------------------------------------------------------
  if (WIDTH < 1)
  begin : g_chk
    $error("mds_parity: WIDTH must be at least 1");
  end
  assign parity_o = ^data_i;
endmodule
`default_nettype wire

// ===== rtl/mds_status_bank.sv
// Status flag bank and register map of a three-phase motor driver.
// Assumes a synchronous register port from the serial front end:
// one-cycle read/write strobes, address and write data held with them.
`timescale 1ns/100ps
`default_nettype none
module mds_status_bank
  import mds_pkg::*;
#(
  parameter int DATA_W = MDS_DATA_W,
  parameter int ADDR_W = MDS_ADDR_W
)
(
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              serial_check_enable_i,
  input  wire logic              otp_read_fault_i,
  input  wire logic              serial_comm_fault_i,
  input  wire logic              overcurrent_i,
  input  wire logic              charge_pump_uv_i,
  input  wire logic              analog_regulator_output_uv_i,
  input  wire logic              analog_regulator_input_uv_i,
  input  wire logic              overtemp_warning_i,
  input  wire logic              overtemp_shutdown_i,
  input  wire logic              regulator_overtemp_shutdown_i,
  input  wire logic [DATA_W-1:0] supply_status_i,
  input  wire logic [DATA_W-1:0] driver_status_i,
  input  wire logic [DATA_W-1:0] system_status_i,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   rvalid_o,
  output logic                   fault_o
);
  // --------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------
  if (DATA_W != 16 || ADDR_W != 8)
  begin : g_chk
    $error("mds_status_bank: only 16-bit data and 8-bit addresses");
  end

  // --------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------
  logic [DATA_W-1:0] device_status_one;
  logic [DATA_W-1:0] overtemp_status;
  logic [DATA_W-1:0] next_device_status_one;
  logic [DATA_W-1:0] next_overtemp_status;
  logic              por_seen;
  logic              next_por_seen;
  logic              any_fault;

  always_comb
  begin
    next_overtemp_status                  = MDS_RST_ZERO;
    next_overtemp_status[MDS_BIT_REG_OTS] = regulator_overtemp_shutdown_i;
    next_overtemp_status[MDS_BIT_OTW]     = overtemp_warning_i;
    next_overtemp_status[MDS_BIT_OVERTEMP_SHUTDOWN]    = overtemp_shutdown_i;
    // Power-on flag is set at reset and kept; no clear path in this bank
    next_por_seen = por_seen;
    any_fault = otp_read_fault_i | serial_comm_fault_i | overcurrent_i
              | charge_pump_uv_i | analog_regulator_output_uv_i
              | analog_regulator_input_uv_i | overtemp_warning_i
              | overtemp_shutdown_i | regulator_overtemp_shutdown_i;
    next_device_status_one                 = MDS_RST_ZERO;
    next_device_status_one[MDS_BIT_OTP]    = otp_read_fault_i;
    next_device_status_one[MDS_BIT_POR]    = next_por_seen;
    next_device_status_one[MDS_BIT_SERIAL] = serial_comm_fault_i;
    next_device_status_one[MDS_BIT_OCP]    = overcurrent_i;
    next_device_status_one[MDS_BIT_UV]     = charge_pump_uv_i
                                           | analog_regulator_output_uv_i
                                           | analog_regulator_input_uv_i;
    next_device_status_one[MDS_BIT_OT]     = overtemp_warning_i
                                           | overtemp_shutdown_i;
    next_device_status_one[MDS_BIT_FAULT]  = any_fault;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      device_status_one <= MDS_RST_DEV_STS;
      overtemp_status   <= MDS_RST_OVERTEMP_STATUS;
      por_seen          <= 1'b1;
    end
    else
    begin
      device_status_one <= next_device_status_one;
      overtemp_status   <= next_overtemp_status;
      por_seen          <= next_por_seen;
    end
  end

  // --------------------------------------------------------------
  // Read/write register file
  // --------------------------------------------------------------
  localparam logic [7:0] RW_OFS [MDS_NUM_RW] = '{
    MDS_OFS_SYNC_PRD, MDS_OFS_FAULT_MODE, MDS_OFS_SYSF_CTL, MDS_OFS_DRVF_CTL,
    MDS_OFS_FLT_TIME, MDS_OFS_FAULT_CLEAR, MDS_OFS_PG_PERIOD, MDS_OFS_PG_DUTY_A,
    MDS_OFS_PG_DUTY_B, MDS_OFS_PG_DUTY_C, MDS_OFS_PWM_STATE, MDS_OFS_PG_CTRL,
    MDS_OFS_PWM_CTL1, MDS_OFS_PREDRV, MDS_OFS_SENSE, MDS_OFS_SYSTEM_CONTROL};
  logic [DATA_W-1:0] rw_reg [MDS_NUM_RW];
  logic [DATA_W-1:0] rw_hit_data [MDS_NUM_RW+1];

  assign rw_hit_data[0] = MDS_RST_ZERO;
  for (genvar i = 0; i < MDS_NUM_RW; i++)
  begin : g_rw
    logic [DATA_W-1:0] next_val;
    always_comb
    begin
      next_val = rw_reg[i];
      if (wr_i && addr_i == RW_OFS[i])
      begin
        next_val = wdata_i;
      end
    end
    always_ff @(posedge core_clk_i)
    begin
      if (!rstn_i)
      begin
        rw_reg[i] <= MDS_RST_RW;
      end
      else
      begin
        rw_reg[i] <= next_val;
      end
    end
    assign rw_hit_data[i+1] = rw_hit_data[i]
                            | ((addr_i == RW_OFS[i]) ? rw_reg[i] : MDS_RST_ZERO);
  end

  // --------------------------------------------------------------
  // Read path with parity
  // --------------------------------------------------------------
  mds_state_t        state;
  mds_state_t        next_state;
  logic [DATA_W-1:0] raw_word;
  logic [DATA_W-1:0] next_rdata;
  logic              next_rvalid;
  logic              next_fault;
  logic              par_bit;
  logic              is_status;

  always_comb
  begin
    is_status = 1'b1;
    case (addr_i)
      MDS_OFS_DEV_STS: raw_word = device_status_one;
      MDS_OFS_OVERTEMP_STATUS:  raw_word = overtemp_status;
      MDS_OFS_SUPPLY_STATUS: raw_word = supply_status_i;
      MDS_OFS_DRIVER_STATUS: raw_word = driver_status_i;
      MDS_OFS_SYSTEM_STATUS: raw_word = system_status_i;
      default:
      begin
        is_status = 1'b0;
        raw_word  = rw_hit_data[MDS_NUM_RW];
      end
    endcase
    // Stored words keep bit 15; only status words have it reserved
    if (is_status)
    begin
      raw_word[MDS_BIT_PARITY] = 1'b0;
    end
  end

  mds_parity #(
    .WIDTH (DATA_W-1)
  ) u_parity (
    .data_i   (raw_word[DATA_W-2:0]),
    .parity_o (par_bit)
  );

  always_comb
  begin
    next_state  = state;
    next_rdata  = rdata_o;
    next_rvalid = 1'b0;
    next_fault  = device_status_one[MDS_BIT_FAULT];
    case (state)
      MDS_ST_IDLE, MDS_ST_DONE:
      begin
        next_state = MDS_ST_IDLE;
        if (rd_i)
        begin
          next_state  = MDS_ST_DONE;
          next_rvalid = 1'b1;
          next_rdata  = raw_word;
          if (serial_check_enable_i)
          begin
            next_rdata[MDS_BIT_PARITY] = par_bit;
          end
        end
      end
      default: next_state = MDS_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      state    <= MDS_ST_IDLE;
      rdata_o  <= MDS_RST_ZERO;
      rvalid_o <= 1'b0;
      fault_o  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      rdata_o  <= next_rdata;
      rvalid_o <= next_rvalid;
      fault_o  <= next_fault;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_read_req;
    rd_i && serial_check_enable_i;
  endsequence

  sequence s_unmapped_rd;
    rd_i && addr_i > MDS_OFS_SENSE && addr_i < MDS_OFS_SYSTEM_CONTROL;
  endsequence

  // Flags are live: each but the power-on flag follows its condition one edge later
  por_flag_a: assert property (device_status_one[MDS_BIT_POR])
    else $error("power-on flag lost");
  otp_flag_a: assert property (
    ##1 device_status_one[MDS_BIT_OTP] == $past(otp_read_fault_i))
    else $error("otp flag wrong");
  serial_flag_a: assert property (serial_comm_fault_i
    |=> device_status_one[MDS_BIT_SERIAL])
    else $error("serial fault flag wrong");
  serial_clear_a: assert property (!serial_comm_fault_i
    |=> !device_status_one[MDS_BIT_SERIAL])
    else $error("serial fault flag stuck");
  ocp_flag_a: assert property (overcurrent_i
    |=> device_status_one[MDS_BIT_OCP] ##1 fault_o)
    else $error("overcurrent flag wrong");
  ocp_clear_a: assert property (!overcurrent_i
    |=> !device_status_one[MDS_BIT_OCP])
    else $error("overcurrent flag stuck");
  uv_flag_a: assert property (analog_regulator_input_uv_i
    |=> device_status_one[MDS_BIT_UV])
    else $error("undervoltage flag wrong");
  uv_out_a: assert property (analog_regulator_output_uv_i
    |=> device_status_one[MDS_BIT_UV])
    else $error("regulator output undervoltage missed");
  cp_uv_a: assert property (charge_pump_uv_i |=> device_status_one[MDS_BIT_UV])
    else $error("charge pump undervoltage missed");
  ot_sum_a: assert property (device_status_one[MDS_BIT_OT]
    == (overtemp_status[MDS_BIT_OTW] || overtemp_status[MDS_BIT_OVERTEMP_SHUTDOWN]))
    else $error("overtemp summary wrong");
  ot_clear_a: assert property (!overtemp_warning_i && !overtemp_shutdown_i
    |=> !device_status_one[MDS_BIT_OT])
    else $error("overtemp summary stuck");
  fault_sum_a: assert property (device_status_one[MDS_BIT_FAULT]
    == (|overtemp_status[2:0] || |device_status_one[8:1] && device_status_one[8:1] != 8'h40))
    else $error("fault summary wrong");
  fault_lag_a: assert property (
    ##1 fault_o == $past(device_status_one[MDS_BIT_FAULT]))
    else $error("fault output lag wrong");
  reg_ots_a: assert property (regulator_overtemp_shutdown_i
    |=> overtemp_status[MDS_BIT_REG_OTS])
    else $error("regulator shutdown flag wrong");
  ots_clear_a: assert property (!regulator_overtemp_shutdown_i
    |=> !overtemp_status[MDS_BIT_REG_OTS])
    else $error("regulator shutdown flag stuck");
  otw_flag_a: assert property (overtemp_warning_i |=> overtemp_status[MDS_BIT_OTW])
    else $error("warning flag wrong");
  overtemp_shutdown_flag_a: assert property (!overtemp_shutdown_i
    |=> !overtemp_status[MDS_BIT_OVERTEMP_SHUTDOWN])
    else $error("shutdown flag wrong");
  parity_out_a: assert property (s_read_req |=> rvalid_o && ^rdata_o == 1'b0)
    else $error("read parity wrong");
  rd_pulse_a: assert property (##1 rvalid_o == $past(rd_i))
    else $error("read answer timing wrong");
  rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data not held");
  no_parity_a: assert property (rd_i && !serial_check_enable_i
    && addr_i == MDS_OFS_OVERTEMP_STATUS |=> !rdata_o[MDS_BIT_PARITY])
    else $error("bit 15 not reserved");
  reserved_a: assert property (device_status_one[14:9] == 6'h00
    && overtemp_status[14:3] == 12'h000)
    else $error("reserved bits set");
  ro_write_a: assert property (wr_i && addr_i == MDS_OFS_DEV_STS
    |=> device_status_one[15:9] == 7'h00 && device_status_one[MDS_BIT_POR])
    else $error("status register written");
  ro_ot_a: assert property (wr_i && addr_i == MDS_OFS_OVERTEMP_STATUS
    |=> overtemp_status[15:3] == 13'h0000
        && overtemp_status[MDS_BIT_OTW] == $past(overtemp_warning_i))
    else $error("overtemp status written");
  unmapped_rd_a: assert property (s_unmapped_rd |=> rdata_o == MDS_RST_ZERO)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== sim/mds_host_model.sv
// Host model: the serial bus primary reduced to the register port strobes.
// Assumes the bank answers a read one cycle after the strobe edge.
`timescale 1ns/100ps
`default_nettype none
module mds_host_model
  import mds_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o
);
  // ------------------------------------------------------------
  // Offsets present in the map
  // ------------------------------------------------------------
  localparam logic [63:0] MAP = 64'h8000000d_3fcd10f1;

  initial
  begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end

  // Unmapped offsets are never written
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    if (a < 8'h40 && MAP[a[5:0]])
    begin
      @(negedge core_clk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(negedge core_clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
    end
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge core_clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge core_clk_i);
    d = rdata_i;
    v = rvalid_i;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// ===== sim/motor_driver_status_registers_test.sv
// Self-checking bench for the motor driver status register bank.
// Assumes the host model drives the register port; flags driven here.
`timescale 1ns/100ps
`default_nettype none
module motor_driver_status_registers_test;
  import mds_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        pen = 1'b0;
  logic [8:0]  cond = 9'h000;
  logic [15:0] sup_w = 16'h0000;
  logic [15:0] drv_w = 16'h0000;
  logic [15:0] sys_w = 16'h0000;
  logic        rd, wr, rvalid, fault;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  int          num_errors = 0;
  int          compares = 0;

  always #10 clk = ~clk;

  mds_host_model host (.core_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd),
    .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

  mds_status_bank uut (.core_clk_i(clk), .rstn_i(rstn), .rd_i(rd), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .serial_check_enable_i(pen),
    .otp_read_fault_i(cond[0]), .serial_comm_fault_i(cond[1]), .overcurrent_i(cond[2]),
    .charge_pump_uv_i(cond[3]), .analog_regulator_output_uv_i(cond[4]),
    .analog_regulator_input_uv_i(cond[5]), .overtemp_warning_i(cond[6]),
    .overtemp_shutdown_i(cond[7]), .regulator_overtemp_shutdown_i(cond[8]),
    .supply_status_i(sup_w), .driver_status_i(drv_w), .system_status_i(sys_w),
    .rdata_o(rdata), .rvalid_o(rvalid), .fault_o(fault));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  function automatic logic [15:0] par(input logic [15:0] w);
    par = pen ? {^w[14:0], w[14:0]} : {1'b0, w[14:0]};
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
    logic [15:0] d;
    logic        v;
    host.read_reg(a, d, v);
    check("rvalid", {15'h0, v}, 16'h0001);
    check($sformatf("reg %h", a), d & m, exp & m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    rd_chk(MDS_OFS_DEV_STS, 16'h0080, 16'hffff);
    rd_chk(MDS_OFS_OVERTEMP_STATUS, 16'h0000, 16'hffff);
    check("fault", {15'h0, fault}, 16'h0000);
    $display("test_reset done");
  endtask

  task automatic test_flags();
    logic [15:0] dev [9] = '{16'h0181, 16'h00c1, 16'h00a1, 16'h0085, 16'h0085,
                             16'h0085, 16'h0083, 16'h0083, 16'h0081};
    logic [15:0] ot [9] = '{0, 0, 0, 0, 0, 0, 16'h0002, 16'h0001, 16'h0004};
    for (int i = 0; i < 9; i++)
    begin
      cond = 9'h001 << i;
      settle(3);
      check("fault", {15'h0, fault}, 16'h0001);
      rd_chk(MDS_OFS_DEV_STS, dev[i], 16'hffff);
      rd_chk(MDS_OFS_OVERTEMP_STATUS, ot[i], 16'hffff);
    end
    cond = 9'h000;
    settle(3);
    check("fault", {15'h0, fault}, 16'h0000);
    rd_chk(MDS_OFS_DEV_STS, 16'h0080, 16'hffff);
    $display("test_flags done");
  endtask

  task automatic test_parity();
    sup_w = 16'h8035;
    drv_w = 16'h0077;
    sys_w = 16'h0017;
    cond = 9'h0c4;
    for (int p = 1; p >= 0; p--)
    begin
      pen = p[0];
      settle(2);
      rd_chk(MDS_OFS_DEV_STS, par(16'h00a3), 16'hffff);
      rd_chk(MDS_OFS_OVERTEMP_STATUS, par(16'h0003), 16'hffff);
      rd_chk(MDS_OFS_SUPPLY_STATUS, par(sup_w), 16'hffff);
      rd_chk(MDS_OFS_DRIVER_STATUS, par(drv_w), 16'hffff);
      rd_chk(MDS_OFS_SYSTEM_STATUS, par(sys_w), 16'hffff);
    end
    cond = 9'h000;
    settle(2);
    $display("test_parity done");
  endtask

  task automatic test_readonly();
    host.write_reg(MDS_OFS_DEV_STS, 16'hffff);
    host.write_reg(MDS_OFS_OVERTEMP_STATUS, 16'hffff);
    settle(2);
    rd_chk(MDS_OFS_DEV_STS, 16'h0080, 16'hffff);
    rd_chk(MDS_OFS_OVERTEMP_STATUS, 16'h0000, 16'hffff);
    $display("test_readonly done");
  endtask

  task automatic test_rw();
    logic [7:0] ofs [16] = '{MDS_OFS_SYNC_PRD, MDS_OFS_FAULT_MODE, MDS_OFS_SYSF_CTL,
      MDS_OFS_DRVF_CTL, MDS_OFS_FLT_TIME, MDS_OFS_FAULT_CLEAR, MDS_OFS_PG_PERIOD,
      MDS_OFS_PG_DUTY_A, MDS_OFS_PG_DUTY_B, MDS_OFS_PG_DUTY_C, MDS_OFS_PWM_STATE,
      MDS_OFS_PG_CTRL, MDS_OFS_PWM_CTL1, MDS_OFS_PREDRV, MDS_OFS_SENSE, MDS_OFS_SYSTEM_CONTROL};
    for (int i = 0; i < 16; i++)
      rd_chk(ofs[i], MDS_RST_RW, 16'hffff);
    for (int i = 0; i < 16; i++)
      host.write_reg(ofs[i], 16'ha5c3 ^ {8'h00, ofs[i]});
    for (int i = 0; i < 16; i++)
      rd_chk(ofs[i], 16'ha5c3 ^ {8'h00, ofs[i]}, 16'hffff);
    rd_chk(8'h01, 16'h0000, 16'hffff);
    rd_chk(8'h3e, 16'h0000, 16'hffff);
    $display("test_rw done");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    settle(2);
    rstn = 1'b1;
    test_reset();
    test_flags();
    test_parity();
    test_readonly();
    test_rw();
    wrap_up();
  end
endmodule
`default_nettype wire
